// ---- shared/iwc_pkg.sv ----
/*
  constants for the interrupt, wake and context save block:
  register map, bit positions, reset values, context layout.
  assumes an 8-bit register bus with a 12-bit address.
*/
`default_nettype none

package iwc_pkg;
  // bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // control and flag register map
  localparam logic [11:0] ADDR_CTRL  = 12'h00B; // irq_control_reg
  localparam logic [11:0] ADDR_FLAG0 = 12'h00C; // irq_flag_reg_zero
  localparam logic [11:0] ADDR_EN0   = 12'h00D; // irq_enable_reg_zero
  localparam logic [11:0] ADDR_PFLAG = 12'h00E; // peripheral flags
  localparam logic [11:0] ADDR_PEN   = 12'h00F; // peripheral enables

  // shadow copies live in the last data bank
  localparam logic [11:0] ADDR_SHADOW = 12'hFE4;

  // field positions
  localparam int BIT_GIE  = 7; // global_irq_enable
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6; // peripheral_irq_enable
  localparam int BIT_EDGE = 0; // ext_edge_select
  localparam int BIT_EXT  = 0; // ext pin flag and enable

  // reset values
  localparam logic RST_EDGE = 1'b1; // rising edge after reset

  // context layout: acc, status, bank, four pointer bytes, pc upper
  localparam int CTX_N = 8;
  localparam int CTX_W = CTX_N * DATA_W;
  localparam int CTX_STATUS = 1;
  // watchdog_expiry_bit and power_down_bit are never saved
  localparam logic [7:0] STATUS_KEEP = 8'h18;

  // fixed vector address
  localparam logic [14:0] VECTOR_ADDR = 15'h0004;

  // sequencer view of this block
  typedef enum logic [1:0] {
    IWC_RUN = 2'b01, // normal code
    IWC_ISR = 2'b10  // inside a service routine
  } iwc_state_t;
endpackage

`default_nettype wire

// ---- src/iwc_pin_edge.sv ----
/*
  external pin edge capture: an async toggle clocked by the pin
  itself, carried into ref_clk by a toggle synchroniser.
  assumes ext_edge_select is steady around pin edges.
*/
`timescale 1ns/1ps
`default_nettype none

module iwc_pin_edge (
  input  wire logic ref_clk,         // system clock
  input  wire logic nrst,            // async reset, low
  input  wire logic ext_pin,         // raw pin
  input  wire logic ext_edge_select, // 1 rising, 0 falling
  output logic      edge_pulse,      // one cycle per edge
  output logic      edge_held        // edge seen, not yet flagged
);
  ////////////////////////////////////////////////////////////
  // pin domain: works with ref_clk stopped in sleep
  logic pin_clk; // selected edge becomes a rising edge
  logic tog;     // flips once per qualifying edge

  assign pin_clk = ~(ext_pin ^ ext_edge_select);

  // toggle clocked by the pin, no system clock needed
  always_ff @(posedge pin_clk or negedge nrst) begin
    if (!nrst) begin
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
    end
  end

  ////////////////////////////////////////////////////////////
  // system domain synchroniser
  typedef struct packed {
    logic s1; // first stage, read only by s2
    logic s2; // stable copy
    logic s3; // previous value for the pulse
  } iwc_edge_st_t;

  iwc_edge_st_t s;
  iwc_edge_st_t next_s;

  // shift the toggle through three stages
  always_comb begin
    next_s    = s;
    next_s.s1 = tog;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // each toggle makes exactly one pulse
  assign edge_pulse = s.s2 ^ s.s3;
  // level for wake while the system clock is stopped
  assign edge_held = tog ^ s.s3;

  chk_edge_once: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    edge_pulse |=> !edge_pulse)
    else $error("pin edge pulse longer than one cycle");
endmodule // iwc_pin_edge

`default_nettype wire

// ---- src/iwc_shadow.sv ----
/*
  shadow context store: bulk save, bulk restore view and a
  software port with registered read data.
  assumes save and software write are single-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module iwc_shadow #(
  parameter int N  = 8, // context words
  parameter int DW = 8  // word width
) (
  input  wire logic                 ref_clk,   // system clock
  input  wire logic                 nrst,      // async reset, low
  input  wire logic                 save,      // bulk capture
  input  wire logic [N*DW-1:0]      save_data, // live context
  input  wire logic                 sw_wr,     // software write
  input  wire logic [$clog2(N)-1:0] sw_idx,    // software word
  input  wire logic [DW-1:0]        sw_wdata,  // software data
  output logic      [DW-1:0]        sw_rdata,  // word at sw_idx
  output logic      [N*DW-1:0]      ctx        // whole store
);
  // a single word leaves no index bits, so two are the minimum
  if (N < 2 || DW < 1) begin : g_bad_param
    $error("N must be at least 2 and DW at least 1");
  end

  typedef struct packed {
    logic [N-1:0][DW-1:0] mem;   // shadow words
    logic [DW-1:0]        rdata; // registered read
  } iwc_sh_st_t;

  iwc_sh_st_t s;
  iwc_sh_st_t next_s;

  // a save beats a software write in the same cycle
  always_comb begin
    next_s = s;
    if (save) begin
      next_s.mem = save_data;
    end else if (sw_wr) begin
      next_s.mem[sw_idx] = sw_wdata;
    end
    next_s.rdata = s.mem[sw_idx];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sw_rdata = s.rdata;
  assign ctx      = s.mem;
endmodule // iwc_shadow

`default_nettype wire

// ---- src/irq_wake_ctx_save.sv ----
/*
  interrupt control: flags, enables, wake request, vector
  entry, return and shadow context save for a small core.
  assumes the core pulses instr_done at each instruction end,
  not while asleep, and acts on the entry and return strobes.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - any enabled source can request wake
// - pin edge captured and wakes without system clock; flag set once it runs
// - wake with global enable set vectors
// - wake with global enable clear continues
// - instruction after sleep completes before vectoring
// - pin edge detected asynchronously
// - pin requests only with its enable
// - edge select one rising, zero falling
// - selected edge sets pin flag
// - flag plus enables redirects to vector
// - entry pushes return pc
// - entry copies context to shadows
// - return reloads context from shadows
// - shadows readable, writable in bank 31
// - entry flushes, clears global enable, loads vector
// - flags set regardless of enables
// - return pops, restores, sets global enable
// - reset leaves global enable clear
module irq_wake_ctx_save
  import iwc_pkg::*;
#(
  parameter int NP = 4 // peripheral sources
) (
  input  wire logic              ref_clk,        // 25 MHz
  input  wire logic              nrst,           // async, low
  // register port
  input  wire logic [ADDR_W-1:0] addr,           // address
  input  wire logic [DATA_W-1:0] wdata,          // write data
  input  wire logic              wr_en,          // write strobe
  input  wire logic              rd_en,          // read strobe
  output logic      [DATA_W-1:0] rdata,          // next cycle
  // event sources
  input  wire logic              ext_pin,        // async pin
  input  wire logic [NP-1:0]     periph_evt,     // set pulses
  // core side
  input  wire logic              core_sleeping,  // in sleep
  input  wire logic              instr_done,     // boundary
  input  wire logic              return_from_isr,// return op
  input  wire logic [CTX_W-1:0]  live_ctx,       // live regs
  output logic                   wake_req,       // wake level
  output logic                   irq_pending,    // request
  output logic                   flush_prefetch, // entry
  output logic                   stack_push,     // entry
  output logic                   pc_load,        // entry
  output logic      [14:0]       pc_vector,      // vector
  output logic                   stack_pop,      // return
  output logic                   ctx_restore,    // return
  output logic      [CTX_W-1:0]  restore_ctx     // shadows
);
  ////////////////////////////////////////////////////////////
  // parameter check
  if (NP < 1 || NP > DATA_W) begin : g_bad_np
    $error("NP must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    iwc_state_t  state;    // run or service
    logic        global_irq_enable;      // global_irq_enable
    logic        peripheral_irq_enable;     // peripheral_irq_enable
    logic        edge_sel; // ext_edge_select
    logic        ext_en;   // ext_pin_irq_enable
    logic        ext_flag; // ext_pin_irq_flag
    logic [NP-1:0] pflag;  // peripheral flags
    logic [NP-1:0] pen;    // peripheral enables
    logic        entry;    // entry strobe
    logic        leave;    // return strobe
    logic [DATA_W-1:0] rd; // register read data
    logic        sh_hit;   // last read was a shadow
  } iwc_top_st_t;

  iwc_top_st_t s;
  iwc_top_st_t next_s;

  logic edge_pulse; // synchronised pin edge
  logic edge_held;  // async edge not yet flagged
  logic pend_ext;   // pin source requesting
  logic pend_per;   // peripheral group requesting
  logic take;       // accept an interrupt now
  logic sh_sel;     // address in the shadow window
  logic [2:0] sh_idx;         // shadow word
  logic [DATA_W-1:0] sh_rdata; // shadow read data
  logic [CTX_W-1:0] save_ctx;  // masked live context

  ////////////////////////////////////////////////////////////
  // pin edge capture
  iwc_pin_edge u_edge (
    .ref_clk         (ref_clk),
    .nrst            (nrst),
    .ext_pin         (ext_pin),
    .ext_edge_select (s.edge_sel),
    .edge_pulse      (edge_pulse),
    .edge_held       (edge_held)
  );

  ////////////////////////////////////////////////////////////
  // request and wake
  assign pend_ext = s.ext_flag & s.ext_en;
  assign pend_per = s.peripheral_irq_enable & (|(s.pflag & s.pen));
  // a set flag with its enables keeps asking
  assign irq_pending = pend_ext | pend_per;
  // wake ignores global enable; only enabled sources wake,
  // and a pin edge wakes before the flag is clocked in
  assign wake_req = irq_pending
                  | (s.ext_en & edge_held);
  // only at an instruction end while awake, so the one
  // instruction after sleep finishes first
  assign take = instr_done & ~core_sleeping
              & s.global_irq_enable & irq_pending;

  ////////////////////////////////////////////////////////////
  // shadow window decode
  assign sh_sel = (addr >= ADDR_SHADOW)
               && (addr < ADDR_SHADOW + 12'(CTX_N));
  assign sh_idx = 3'(addr - ADDR_SHADOW);

  // status keeps watchdog and power-down bits out of the save
  always_comb begin
    save_ctx = live_ctx;
    save_ctx[CTX_STATUS*DATA_W +: DATA_W] =
      live_ctx[CTX_STATUS*DATA_W +: DATA_W]
      & ~STATUS_KEEP;
  end

  iwc_shadow #(
    .N  (CTX_N),
    .DW (DATA_W)
  ) u_shadow (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .save      (take),
    .save_data (save_ctx),
    .sw_wr     (wr_en & sh_sel),
    .sw_idx    (sh_idx),
    .sw_wdata  (wdata),
    .sw_rdata  (sh_rdata),
    .ctx       (restore_ctx)
  );

  ////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s        = s;
    next_s.entry  = take;
    next_s.leave  = return_from_isr;
    next_s.rd     = '0;
    next_s.sh_hit = rd_en & sh_sel;

    // register writes
    if (wr_en) begin
      case (addr)
        ADDR_CTRL: begin
          next_s.global_irq_enable      = wdata[BIT_GIE];
          next_s.peripheral_irq_enable     = wdata[BIT_PERIPHERAL_IRQ_ENABLE];
          next_s.edge_sel = wdata[BIT_EDGE];
        end
        ADDR_FLAG0: begin
          next_s.ext_flag = wdata[BIT_EXT];
        end
        ADDR_EN0: begin
          next_s.ext_en = wdata[BIT_EXT];
        end
        ADDR_PFLAG: begin
          next_s.pflag = wdata[NP-1:0];
        end
        ADDR_PEN: begin
          next_s.pen = wdata[NP-1:0];
        end
        default: begin
          // unmapped or shadow: nothing here
        end
      endcase
    end

    // hardware sets win over software clears
    if (edge_pulse) begin
      next_s.ext_flag = 1'b1;
    end
    next_s.pflag = next_s.pflag | periph_evt;

    // interrupt entry and return
    case (s.state)
      IWC_RUN: begin
        if (take) begin
          next_s.global_irq_enable   = 1'b0;
          next_s.state = IWC_ISR;
        end
      end
      IWC_ISR: begin
        if (return_from_isr) begin
          next_s.state = IWC_RUN;
        end
      end
      default: begin
        next_s.state = IWC_RUN;
      end
    endcase
    // return also recovers a stray return in run state
    if (return_from_isr) begin
      next_s.global_irq_enable = 1'b1;
    end

    // register reads
    if (rd_en) begin
      case (addr)
        ADDR_CTRL: begin
          next_s.rd[BIT_GIE]  = s.global_irq_enable;
          next_s.rd[BIT_PERIPHERAL_IRQ_ENABLE] = s.peripheral_irq_enable;
          next_s.rd[BIT_EDGE] = s.edge_sel;
        end
        ADDR_FLAG0: begin
          next_s.rd[BIT_EXT] = s.ext_flag;
        end
        ADDR_EN0: begin
          next_s.rd[BIT_EXT] = s.ext_en;
        end
        ADDR_PFLAG: begin
          next_s.rd[NP-1:0] = s.pflag;
        end
        ADDR_PEN: begin
          next_s.rd[NP-1:0] = s.pen;
        end
        default: begin
          // unmapped reads return zero
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // state register; reset clears every enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s          <= '0;
      s.state    <= IWC_RUN;
      s.edge_sel <= RST_EDGE;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs
  assign flush_prefetch = s.entry;
  assign stack_push     = s.entry;
  assign pc_load        = s.entry;
  assign pc_vector      = VECTOR_ADDR;
  assign stack_pop      = s.leave;
  assign ctx_restore    = s.leave;
  assign rdata = s.sh_hit ? sh_rdata : s.rd;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence seq_entry;
    flush_prefetch && stack_push && pc_load && !s.global_irq_enable;
  endsequence

  sequence seq_restore;
    ctx_restore && stack_pop && s.global_irq_enable ##1 !ctx_restore;
  endsequence

  chk_entry_seq: assert property (
    take |=> seq_entry)
    else $error("entry strobes missing after take");

  chk_entry_cause: assert property (
    pc_load |-> $past(s.global_irq_enable) && $past(instr_done))
    else $error("vector without enable or boundary");

  chk_no_sleep_take: assert property (
    core_sleeping |=> !pc_load)
    else $error("vector taken while asleep");

  chk_return_seq: assert property (
    return_from_isr |=> seq_restore)
    else $error("return strobes wrong");

  chk_shadow_save: assert property (
    take && !return_from_isr |=>
      restore_ctx == $past(save_ctx))
    else $error("shadow did not capture context");

  chk_flag_set: assert property (
    edge_pulse |=> s.ext_flag)
    else $error("pin edge lost");

  chk_flag_sticky: assert property (
    s.ext_flag && !(wr_en && addr == ADDR_FLAG0)
      |=> s.ext_flag)
    else $error("pin flag dropped by itself");

  chk_wake_gate: assert property (
    !s.ext_en && !(s.peripheral_irq_enable && |(s.pflag & s.pen))
      |-> !wake_req)
    else $error("wake from disabled source");

  chk_read_zero: assert property (
    !rd_en |=> rdata == '0)
    else $error("read data outside read slot");
endmodule // irq_wake_ctx_save

`default_nettype wire

// ---- verif/iwc_core_model.sv ----
/*
  behavioural core sequencer model: instruction boundaries,
  sleep and wake, return requests and stack push and pop counters.
  assumes one clock and the entry and return strobes of the dut.
*/
`timescale 1ns/1ps
`default_nettype none

module iwc_core_model (
  input  wire logic       ref_clk,         // system clock
  input  wire logic       nrst,            // async reset, low
  input  wire logic       go_sleep,        // bench: run sleep op
  input  wire logic       ret_req,         // bench: run return op
  input  wire logic       wake_req,        // dut wake level
  input  wire logic       stack_push,      // dut entry push
  input  wire logic       stack_pop,       // dut return pop
  output logic            core_sleeping,   // asleep level
  output logic            instr_done,      // boundary pulse
  output logic            return_from_isr, // return op pulse
  output logic      [7:0] n_push,          // pushes seen
  output logic      [7:0] n_pop,           // pops seen
  output logic      [7:0] n_after_wake     // boundaries since wake
);
  logic [1:0] tick; // four-cycle instructions

  ////////////////////////////////////////////////////////////////
  // sequencer: no boundary while asleep; a wake restarts the
  // instruction counter so the op after sleep runs in full
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick            <= 2'd0;
      core_sleeping   <= 1'b0;
      instr_done      <= 1'b0;
      return_from_isr <= 1'b0;
      n_push          <= 8'h00;
      n_pop           <= 8'h00;
      n_after_wake    <= 8'h00;
    end else begin
      tick            <= tick + 2'd1;
      instr_done      <= !core_sleeping && !go_sleep && tick == 2'd3;
      return_from_isr <= ret_req;
      if (stack_push) n_push <= n_push + 8'h01;
      if (stack_pop) n_pop <= n_pop + 8'h01;
      if (instr_done) n_after_wake <= n_after_wake + 8'h01;
      if (go_sleep) begin
        core_sleeping <= 1'b1;
      end else if (core_sleeping && wake_req) begin
        // instruction after sleep completes before any vector
        core_sleeping <= 1'b0;
        tick          <= 2'd0;
        n_after_wake  <= 8'h00;
      end
    end
  end
endmodule // iwc_core_model

`default_nettype wire

// ---- verif/irq_wake_ctx_save_tb.sv ----
/*
  self-checking bench for the interrupt, wake and context block.
  assumes the core model above stands on the core side.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_wake_ctx_save_tb;
  import iwc_pkg::*;
  logic              ref_clk = 1'b0;    // 25 MHz
  logic              nrst = 1'b0;       // async reset, low
  logic [ADDR_W-1:0] addr = '0;         // register address
  logic [DATA_W-1:0] wdata = '0;        // write data
  logic              wr_en = 1'b0;      // write strobe
  logic              rd_en = 1'b0;      // read strobe
  logic [DATA_W-1:0] rdata;             // read data
  logic              ext_pin = 1'b0;    // external pin
  logic [3:0]        periph_evt = '0;   // peripheral events
  logic [CTX_W-1:0]  live_ctx = '0;     // live context
  logic              go_sleep = 1'b0;   // model sleep op
  logic              ret_req = 1'b0;    // model return op
  logic core_sleeping, instr_done, return_from_isr, wake_req;
  logic irq_pending, flush_prefetch, stack_push, pc_load;
  logic stack_pop, ctx_restore;
  logic [14:0]       pc_vector;
  logic [CTX_W-1:0]  restore_ctx;
  logic [7:0]        n_push, n_pop, n_after_wake;
  int                n_fail = 0;
  int                n_tests = 0;
  int                cycles = 0;

  always #20 ref_clk = ~ref_clk;

  irq_wake_ctx_save #(.NP(4)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_pin(ext_pin),
    .periph_evt(periph_evt), .core_sleeping(core_sleeping),
    .instr_done(instr_done), .return_from_isr(return_from_isr),
    .live_ctx(live_ctx), .wake_req(wake_req),
    .irq_pending(irq_pending), .flush_prefetch(flush_prefetch),
    .stack_push(stack_push), .pc_load(pc_load),
    .pc_vector(pc_vector), .stack_pop(stack_pop),
    .ctx_restore(ctx_restore), .restore_ctx(restore_ctx));

  iwc_core_model core (
    .ref_clk(ref_clk), .nrst(nrst), .go_sleep(go_sleep),
    .ret_req(ret_req), .wake_req(wake_req),
    .stack_push(stack_push), .stack_pop(stack_pop),
    .core_sleeping(core_sleeping), .instr_done(instr_done),
    .return_from_isr(return_from_isr), .n_push(n_push),
    .n_pop(n_pop), .n_after_wake(n_after_wake));

  ////////////////////////////////////////////////////////////////
  // verdict and hang guard
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // a few thousand cycles cover every test with wide margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // bounded wait for a one-cycle strobe, checked while it stands
  task automatic wait_pc();
    for (int i = 0; i < 40 && pc_load !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic do_return(input logic [7:0] w0);
    wr(ADDR_FLAG0, 8'h00);
    @(posedge ref_clk);
    ret_req <= 1'b1;
    @(posedge ref_clk);
    ret_req <= 1'b0;
    for (int i = 0; i < 8 && ctx_restore !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(ctx_restore, 1'b1);
    chk(stack_pop, 1'b1);
    chk(restore_ctx[7:0], w0);
    rdchk(ADDR_CTRL, 8'h81);
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rdchk(ADDR_CTRL, 8'h01);
    rdchk(ADDR_FLAG0, 8'h00);
    rdchk(ADDR_EN0, 8'h00);
    rdchk(12'h123, 8'h00);
    chk(wake_req, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_pin();
    @(posedge ref_clk) ext_pin <= 1'b1;
    cyc(6);
    rdchk(ADDR_FLAG0, 8'h01);
    wr(ADDR_FLAG0, 8'h00);
    rdchk(ADDR_FLAG0, 8'h00);
    @(posedge ref_clk) ext_pin <= 1'b0;
    cyc(6);
    rdchk(ADDR_FLAG0, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    cyc(6);
    wr(ADDR_FLAG0, 8'h00);
    @(posedge ref_clk) ext_pin <= 1'b1;
    cyc(6);
    rdchk(ADDR_FLAG0, 8'h00);
    @(posedge ref_clk) ext_pin <= 1'b0;
    cyc(6);
    rdchk(ADDR_FLAG0, 8'h01);
    rdchk(ADDR_FLAG0, 8'h01);
    chk(irq_pending, 1'b0);
    wr(ADDR_CTRL, 8'h01);
    cyc(6);
    wr(ADDR_FLAG0, 8'h00);
    $display("test pin done");
  endtask

  task automatic t_entry();
    @(posedge ref_clk) live_ctx <= 64'h1122_3344_5566_FF77;
    wr(ADDR_CTRL, 8'h81);
    wr(ADDR_EN0, 8'h01);
    @(posedge ref_clk) ext_pin <= 1'b1;
    wait_pc();
    chk(pc_load, 1'b1);
    chk(flush_prefetch, 1'b1);
    chk(stack_push, 1'b1);
    chk(pc_vector, 15'h0004);
    chk(restore_ctx, 64'h1122_3344_5566_E777);
    @(posedge ref_clk) live_ctx <= 64'h0;
    #1 chk(n_push, 8'h01);
    rdchk(ADDR_CTRL, 8'h01);
    chk(irq_pending, 1'b1);
    wr(ADDR_SHADOW, 8'hA5);
    rdchk(ADDR_SHADOW, 8'hA5);
    rdchk(ADDR_SHADOW + 12'h007, 8'h11);
    do_return(8'hA5);
    chk(n_pop, 8'h01);
    @(posedge ref_clk) ext_pin <= 1'b0;
    $display("test entry done");
  endtask

  task automatic t_sleep_cont();
    int hits;
    hits = 0;
    wr(ADDR_EN0, 8'h00);
    wr(ADDR_CTRL, 8'h41);
    wr(ADDR_PFLAG, 8'h00);
    @(posedge ref_clk) go_sleep <= 1'b1;
    @(posedge ref_clk) go_sleep <= 1'b0;
    periph_evt <= 4'h1;
    @(posedge ref_clk) periph_evt <= 4'h0;
    cyc(3);
    chk(wake_req, 1'b0);
    chk(core_sleeping, 1'b1);
    rdchk(ADDR_PFLAG, 8'h01);
    wr(ADDR_PEN, 8'h01);
    cyc(2);
    chk(core_sleeping, 1'b0);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      #1 hits += int'(pc_load !== 1'b0);
    end
    chk(hits, 0);
    chk(n_after_wake > 8'h00, 1'b1);
    wr(ADDR_PEN, 8'h00);
    wr(ADDR_PFLAG, 8'h00);
    $display("test sleep continue done");
  endtask

  task automatic t_sleep_vec();
    // a fresh accumulator value, so the second save is visible
    @(posedge ref_clk) live_ctx <= 64'h0000_0000_0000_005A;
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_FLAG0, 8'h00);
    wr(ADDR_EN0, 8'h01);
    @(posedge ref_clk) go_sleep <= 1'b1;
    @(posedge ref_clk) go_sleep <= 1'b0;
    wr(ADDR_CTRL, 8'h81);
    @(posedge ref_clk) ext_pin <= 1'b1;
    #1 chk(wake_req, 1'b1);
    wait_pc();
    chk(pc_load, 1'b1);
    chk(n_after_wake, 8'h01);
    do_return(8'h5A);
    @(posedge ref_clk) ext_pin <= 1'b0;
    $display("test sleep vector done");
  endtask

  initial begin
    cyc(6);
    nrst <= 1'b1;
    t_reset();
    t_pin();
    t_entry();
    t_sleep_cont();
    t_sleep_vec();
    conclude();
  end
endmodule // irq_wake_ctx_save_tb

`default_nettype wire
